// ===== core/hec_command_set.sv
// Hub endpoint and port command interpreter
`include "hec_consts.svh"
module hec_command_set
	import hec_pkg::*;
#(
	parameter int                NUM_EP            = 5,
	parameter int                NUM_PORTS         = 4,
	parameter logic [NUM_EP-1:0] EP_IN_MASK        = 5'h0A,
	parameter int                PORT_RESET_CYCLES = `HEC_PORT_RESET_MS * `HEC_CLK_KHZ,
	parameter int                RESUME_CYCLES     = `HEC_RESUME_MS * `HEC_CLK_KHZ
)(
	input  wire logic                 clk,                // Core clock
	input  wire logic                 reset,              // Async reset, active high
	input  wire logic                 link_clk,           // Link clock
	input  wire logic                 link_cmd_valid,     // Command byte strobe
	input  wire logic                 link_wr_valid,      // Data write strobe
	input  wire logic                 link_rd_req,        // Data read request
	input  wire hec_byte_t            link_wdata,         // Command or write byte
	output logic                      link_rd_valid,      // Read byte ready
	output hec_byte_t                 link_rdata,         // Read byte
	input  wire logic [NUM_EP-1:0]    usb_out_done,       // OUT packet received
	input  wire logic [NUM_EP-1:0]    usb_in_sent,        // IN packet acknowledged
	input  wire logic                 usb_setup,          // SETUP packet received
	input  wire logic                 usb_sof_valid,      // Good start of frame
	input  wire logic [10:0]          usb_sof_frame,      // Its frame number
	output logic [NUM_EP-1:0]         ep_full,            // Buffer full
	output logic [NUM_EP-1:0]         ep_stall,           // Endpoint stalled
	output logic [NUM_EP-1:0]         ep_data1,           // Next PID is DATA1
	input  wire logic                 cfg_mode,           // Mode pin
	input  wire logic [NUM_PORTS-1:0] port_connect,       // Device attached pins
	input  wire logic [NUM_PORTS-1:0] port_low_speed,     // Low speed pins
	input  wire logic [NUM_PORTS-1:0] port_overcurrent_n, // Overcurrent pins
	input  wire logic [NUM_PORTS-1:0] port_resume,        // Downstream resume pins
	output logic                      port_power,         // Ganged power switch
	output logic [NUM_PORTS-1:0]      port_enable,        // Port enabled
	output logic [NUM_PORTS-1:0]      port_suspend,       // Port suspended
	output logic [NUM_PORTS-1:0]      port_bus_reset,     // Port bus reset drive
	output logic                      upstream_resume,    // Upstream resume drive
	output logic [NUM_PORTS+1:0]      hub_change          // Hub change report
);
	localparam int RW   = $clog2(PORT_RESET_CYCLES + 1);
	localparam int RSW  = $clog2(RESUME_CYCLES + 1);
	localparam int NPIN = 1 + 4 * NUM_PORTS;

	// ==========================================
	// Link domain front end
	hec_link_if lk ();
	hec_link u_link (
		.link_clk       (link_clk),
		.reset          (reset),
		.link_cmd_valid (link_cmd_valid),
		.link_wr_valid  (link_wr_valid),
		.link_rd_req    (link_rd_req),
		.link_wdata     (link_wdata),
		.link_rd_valid  (link_rd_valid),
		.link_rdata     (link_rdata),
		.lk             (lk)
	);

	// ==========================================
	// Synchronisers
	logic [NPIN-1:0] pin_meta, pin_sync;
	logic [2:0]      tg_meta, tg_sync, tg_last;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_meta <= '0;
			pin_sync <= '0;
			tg_meta  <= '0;
			tg_sync  <= '0;
			tg_last  <= '0;
		end else begin
			pin_meta <= {cfg_mode, port_connect, port_low_speed, port_overcurrent_n, port_resume};
			pin_sync <= pin_meta;
			tg_meta  <= {lk.rd_tgl, lk.wr_tgl, lk.cmd_tgl};
			tg_sync  <= tg_meta;
			tg_last  <= tg_sync;
		end
	end

	logic                 mode1;
	logic [NUM_PORTS-1:0] conn_s, low_s, oc_n_s, res_s;
	assign mode1  = pin_sync[NPIN-1];
	assign conn_s = pin_sync[4*NUM_PORTS-1 -: NUM_PORTS];
	assign low_s  = pin_sync[3*NUM_PORTS-1 -: NUM_PORTS];
	assign oc_n_s = pin_sync[2*NUM_PORTS-1 -: NUM_PORTS];
	assign res_s  = pin_sync[NUM_PORTS-1:0];

	logic      ev_cmd, ev_wr, ev_rd;
	hec_byte_t din;
	assign ev_cmd = tg_sync[0] ^ tg_last[0];
	assign ev_wr  = tg_sync[1] ^ tg_last[1];
	assign ev_rd  = tg_sync[2] ^ tg_last[2];
	assign din    = lk.wr_byte;

	// ==========================================
	// Command and phase tracking
	function automatic logic in_range(input hec_byte_t code, input hec_byte_t base, input int n);
		return hec_byte_t'(code - base) < hec_byte_t'(n);
	endfunction

	hec_byte_t  cur_cmd;
	hec_phase_e phase;
	logic [2:0] sel_ep;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cur_cmd <= '0;
			phase   <= ph_idle;
			sel_ep  <= '0;
		end else if (ev_cmd) begin
			cur_cmd <= din;
			phase   <= ph_first;
			if (in_range(din, `HEC_CMD_SELECT, NUM_EP))
				sel_ep <= din[2:0];
		end else if (ev_wr || ev_rd) begin
			unique case (phase)
				ph_idle:   phase <= ph_idle;
				ph_first:  phase <= ph_second;
				ph_second: phase <= ph_done;
				ph_done:   phase <= ph_done;
			endcase
		end
	end

	logic       first_wr, now_valid, now_clear, now_ack, now_resume;
	logic       wr_ep_stat, wr_clr, wr_set, set_pwr, clr_pwr;
	logic [2:0] stat_ep;
	logic [1:0] f_port;
	assign first_wr   = ev_wr && phase == ph_first;
	assign now_valid  = ev_cmd && din == `HEC_CMD_VALIDATE;
	assign now_clear  = ev_cmd && din == `HEC_CMD_CLEAR_BUF;
	assign now_ack    = ev_cmd && din == `HEC_CMD_ACK_SETUP;
	assign now_resume = ev_cmd && din == `HEC_CMD_RESUME;
	assign wr_ep_stat = first_wr && in_range(cur_cmd, `HEC_CMD_EP_STATUS, NUM_EP);
	assign wr_clr     = first_wr && in_range(cur_cmd, `HEC_CMD_CLR_FEAT, NUM_PORTS);
	assign wr_set     = first_wr && in_range(cur_cmd, `HEC_CMD_SET_FEAT, NUM_PORTS);
	assign set_pwr    = wr_set && din == `HEC_F_POWER;
	assign clr_pwr    = wr_clr && din == `HEC_F_POWER;
	assign stat_ep    = cur_cmd[2:0];
	assign f_port     = cur_cmd[1:0];

	// ==========================================
	// Endpoint buffer handshake
	logic [NUM_EP-1:0] is_ctrl, sel_hit, stat_hit, reinit, set_full, clr_full, xfer_done, setup_lock;
	always_comb begin
		for (int i = 0; i < NUM_EP; i++) begin
			is_ctrl[i]   = (i == `HEC_EP_CTRL_OUT) || (i == `HEC_EP_CTRL_IN);
			sel_hit[i]   = sel_ep == 3'(i) && !setup_lock[i];
			stat_hit[i]  = wr_ep_stat && stat_ep == 3'(i);
			reinit[i]    = (stat_hit[i] && (din == '0 || (ep_stall[i] && !din[`HEC_EP_STALL_BIT])))
				|| (usb_setup && is_ctrl[i] && ep_stall[i]);
			set_full[i]  = (usb_out_done[i] && !EP_IN_MASK[i])
				|| (usb_setup && i == `HEC_EP_CTRL_OUT)
				|| (now_valid && sel_hit[i]);
			clr_full[i]  = (now_clear && sel_hit[i]) || usb_in_sent[i] || reinit[i];
			xfer_done[i] = EP_IN_MASK[i] ? usb_in_sent[i] : usb_out_done[i];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ep_full    <= '0;
			ep_stall   <= '0;
			ep_data1   <= '0;
			setup_lock <= '0;
		end else begin
			for (int i = 0; i < NUM_EP; i++) begin
				if (usb_setup && i == `HEC_EP_CTRL_IN)
					ep_full[i] <= 1'b0;
				else
					ep_full[i] <= set_full[i] | (ep_full[i] & ~clr_full[i]);
				if (usb_setup && is_ctrl[i])
					ep_stall[i] <= 1'b0;
				else if (stat_hit[i])
					ep_stall[i] <= din[`HEC_EP_STALL_BIT];
				ep_data1[i]   <= reinit[i] ? 1'b0 : ep_data1[i] ^ xfer_done[i];
				setup_lock[i] <= (usb_setup && is_ctrl[i])
					| (setup_lock[i] & ~(now_ack && sel_ep == 3'(i)));
			end
		end
	end

	// ==========================================
	// Downstream ports
	function automatic logic clr_hit(input int p, input hec_byte_t code);
		return wr_clr && f_port == 2'(p) && din == code;
	endfunction
	function automatic logic set_hit(input int p, input hec_byte_t code);
		return wr_set && f_port == 2'(p) && din == code;
	endfunction

	logic [NUM_PORTS-1:0] oc_armed, oc_now, oc_last, conn_last, rst_done;
	logic [NUM_PORTS-1:0] chg_conn, chg_en, chg_susp, chg_rst, chg_oc;
	logic                 chg_oc_hub;
	logic [RW-1:0]        rst_cnt [NUM_PORTS];

	assign oc_now = oc_armed & (mode1 ? ~oc_n_s : {NUM_PORTS{~oc_n_s[0]}});
	always_comb begin
		for (int i = 0; i < NUM_PORTS; i++)
			rst_done[i] = port_bus_reset[i] && rst_cnt[i] == RW'(1);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			port_power     <= 1'b0;
			oc_armed       <= '0;
			oc_last        <= '0;
			conn_last      <= '0;
			port_enable    <= '0;
			port_suspend   <= '0;
			port_bus_reset <= '0;
			chg_conn       <= '0;
			chg_en         <= '0;
			chg_susp       <= '0;
			chg_rst        <= '0;
			chg_oc         <= '0;
			chg_oc_hub     <= 1'b0;
			for (int i = 0; i < NUM_PORTS; i++)
				rst_cnt[i] <= '0;
		end else begin
			conn_last <= conn_s;
			oc_last   <= oc_now;
			if (clr_pwr)
				port_power <= 1'b0;
			else if (set_pwr)
				port_power <= 1'b1;
			chg_oc_hub <= (|(oc_now & ~oc_last))
				| (chg_oc_hub & ~(!mode1 && wr_clr && din == `HEC_C_OVERCUR));
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (clr_pwr)
					oc_armed[i] <= 1'b0;
				else if (set_pwr && port_power && (!mode1 || f_port == 2'(i)))
					oc_armed[i] <= 1'b1;
				if (!conn_s[i] || !port_power || oc_now[i] || clr_hit(i, `HEC_F_ENABLE))
					port_enable[i] <= 1'b0;
				else if (set_hit(i, `HEC_F_ENABLE) || rst_done[i])
					port_enable[i] <= 1'b1;
				if (set_hit(i, `HEC_F_SUSPEND))
					port_suspend[i] <= 1'b1;
				else if (clr_hit(i, `HEC_F_SUSPEND) || !conn_s[i])
					port_suspend[i] <= 1'b0;
				if (set_hit(i, `HEC_F_RESET) && conn_s[i]) begin
					port_bus_reset[i] <= 1'b1;
					rst_cnt[i]        <= RW'(PORT_RESET_CYCLES);
				end else if (port_bus_reset[i]) begin
					rst_cnt[i] <= rst_cnt[i] - 1'b1;
					if (rst_done[i])
						port_bus_reset[i] <= 1'b0;
				end
				chg_conn[i] <= (conn_s[i] ^ conn_last[i]) | (chg_conn[i] & ~clr_hit(i, `HEC_C_CONNECT));
				chg_en[i]   <= (oc_now[i] & ~oc_last[i] & port_enable[i])
					| (chg_en[i] & ~clr_hit(i, `HEC_C_ENABLE));
				chg_susp[i] <= (clr_hit(i, `HEC_F_SUSPEND) & port_suspend[i])
					| (chg_susp[i] & ~clr_hit(i, `HEC_C_SUSPEND));
				chg_rst[i]  <= rst_done[i] | (chg_rst[i] & ~clr_hit(i, `HEC_F_RESET));
				chg_oc[i]   <= (oc_now[i] & ~oc_last[i])
					| (chg_oc[i] & ~(mode1 && clr_hit(i, `HEC_C_OVERCUR)));
			end
		end
	end

	// ==========================================
	// Status and change bytes
	hec_byte_t stat_byte [NUM_PORTS];
	hec_byte_t chg_byte  [NUM_PORTS];
	always_comb begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			stat_byte[i]                  = '0;
			stat_byte[i][`HEC_ST_CONNECT] = conn_s[i];
			stat_byte[i][`HEC_ST_ENABLE]  = port_enable[i];
			stat_byte[i][`HEC_ST_SUSPEND] = port_suspend[i];
			stat_byte[i][`HEC_ST_OVERCUR] = oc_now[i];
			stat_byte[i][`HEC_ST_RESET]   = port_bus_reset[i];
			stat_byte[i][`HEC_ST_POWER]   = port_power;
			stat_byte[i][`HEC_ST_LOWSPD]  = low_s[i] & conn_s[i];
			chg_byte[i]                   = '0;
			chg_byte[i][`HEC_ST_CONNECT]  = chg_conn[i];
			chg_byte[i][`HEC_ST_ENABLE]   = chg_en[i];
			chg_byte[i][`HEC_ST_SUSPEND]  = chg_susp[i];
			chg_byte[i][`HEC_ST_OVERCUR]  = mode1 ? chg_oc[i] : chg_oc_hub;
			chg_byte[i][`HEC_ST_RESET]    = chg_rst[i];
		end
	end

	// ==========================================
	// Controller change bits and hub report
	logic [1:0]           ctl_chg;
	logic [NUM_PORTS+1:0] next_hub_change;
	always_comb begin
		next_hub_change                 = '0;
		next_hub_change[`HEC_CHG_LOCAL] = ctl_chg[`HEC_CHG_LOCAL] | (!mode1 & chg_oc_hub);
		next_hub_change[`HEC_CHG_EMBED] = ctl_chg[`HEC_CHG_EMBED];
		for (int i = 0; i < NUM_PORTS; i++)
			next_hub_change[i+2] = |chg_byte[i];
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctl_chg    <= '0;
			hub_change <= '0;
		end else begin
			if (first_wr && cur_cmd == `HEC_CMD_CHG_BITS)
				ctl_chg <= din[1:0];
			hub_change <= next_hub_change;
		end
	end

	// ==========================================
	// Frame number and read answers
	logic [10:0] frame_num;
	hec_byte_t   next_rd;
	always_comb begin
		next_rd = '0;
		if (in_range(cur_cmd, `HEC_CMD_CLR_FEAT, NUM_PORTS) && phase == ph_first)
			next_rd = stat_byte[f_port];
		else if (in_range(cur_cmd, `HEC_CMD_CLR_FEAT, NUM_PORTS) && phase == ph_second)
			next_rd = chg_byte[f_port];
		else if (cur_cmd == `HEC_CMD_FRAME && phase == ph_first)
			next_rd = frame_num[7:0];
		else if (cur_cmd == `HEC_CMD_FRAME && phase == ph_second)
			next_rd = 8'(frame_num[10:8]);
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			frame_num     <= '0;
			lk.rd_byte    <= '0;
			lk.rd_ack_tgl <= 1'b0;
		end else begin
			if (usb_sof_valid)
				frame_num <= usb_sof_frame;
			if (ev_rd) begin
				lk.rd_byte    <= next_rd;
				lk.rd_ack_tgl <= ~lk.rd_ack_tgl;
			end
		end
	end

	// ==========================================
	// Upstream resume
	logic [NUM_PORTS-1:0] res_last;
	logic [RSW-1:0]       res_cnt;
	logic                 res_start;
	assign res_start = now_resume || |(res_s & ~res_last);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			res_last        <= '0;
			res_cnt         <= '0;
			upstream_resume <= 1'b0;
		end else begin
			res_last <= res_s;
			if (now_resume || (res_start && !upstream_resume)) begin
				upstream_resume <= 1'b1;
				res_cnt         <= RSW'(RESUME_CYCLES);
			end else if (upstream_resume) begin
				res_cnt <= res_cnt - 1'b1;
				if (res_cnt == RSW'(1))
					upstream_resume <= 1'b0;
			end
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	out_full_a: assert property (usb_out_done[0] |=> ep_full[0])
		else $error("Received packet did not fill buffer");
	validate_full_a: assert property (now_valid && !setup_lock[sel_ep] && !usb_setup |=> ep_full[$past(sel_ep)])
		else $error("Validate did not fill buffer");
	setup_unstall_a: assert property (usb_setup |=> !ep_stall[0] && !ep_stall[1])
		else $error("Control endpoint stayed stalled after setup");
	zero_reinit_a: assert property (wr_ep_stat && din == '0 |=> !ep_data1[$past(stat_ep)])
		else $error("Zero status write did not restart at data0");
	setup_flush_a: assert property (usb_setup |=> !ep_full[1] && setup_lock[0] && setup_lock[1])
		else $error("Setup did not flush and lock");
	lock_ignore_a: assert property (setup_lock[1] && !ep_full[1] && now_valid && sel_ep == 3'd1 |=> !ep_full[1])
		else $error("Validate taken while setup unacknowledged");
	power_first_a: assert property (set_pwr && !port_power |=> port_power && oc_armed == '0)
		else $error("First power set armed detection");
	power_off_a: assert property (clr_pwr |=> !port_power ##0 oc_armed == '0)
		else $error("Power clear left power or detection on");
	reset_done_a: assert property ($fell(port_bus_reset[0]) |-> chg_rst[0] && port_enable[0])
		else $error("Port reset ended without change bit");
	low_speed_a: assert property (!conn_s[0] |-> !stat_byte[0][`HEC_ST_LOWSPD])
		else $error("Low speed shown without connection");
	resume_hold_a: assert property (now_resume |=> upstream_resume [*8])
		else $error("Resume signalling too short");
	frame_take_a: assert property (usb_sof_valid |=> frame_num == $past(usb_sof_frame))
		else $error("Frame number not captured");

	setup_ack_c: cover property (usb_setup ##[1:200] (now_ack && sel_ep == 3'd1));
	port_reset_c: cover property ($fell(port_bus_reset[0]));
	resume_c: cover property ($fell(upstream_resume));
endmodule // hec_command_set

// ===== shared/hec_consts.svh
// Command codes, field positions and timing constants of the hub command interpreter
// Behaviour
// - A fully received OUT packet marks its buffer full until the clear-buffer command.
// - Validate-buffer marks an IN buffer full, so its data goes out next.
// - Endpoint status write sets stall; SETUP unstalls a control endpoint.
// - Leaving stall or writing status zero flushes the buffer and restarts at DATA0.
// - SETUP flushes the IN buffer and blocks validate and clear until acknowledged.
// - Feature clear codes sit at E0h-E3h, set at E8h-EBh, each with one byte.
// - In mode zero power and overcurrent change ignore the named port.
// - In mode one power arms per port, overcurrent inputs are per port.
// - Power set turns power on, a second set arms detection; clear drops both.
// - Codes 0-3 act on enable, suspend, reset and power of a port.
// - Codes 4-7 clear connect, enable, suspend and overcurrent change bits.
// - Port status read returns the status byte, then the change byte.
// - Status reports seven flags; reset flag is high for the port reset time.
// - Power reads the same for all ports; mode zero shares overcurrent too.
// - Low-speed reads only while the port is connected.
// - Each change bit is one only after its status has changed.
// - Change-bits command takes one byte: local power and embedded change bits.
// - Resume command drives upstream resume for ten milliseconds.
// - A downstream resume event starts upstream resume on its own.
// - Frame number command returns the last good frame number, low byte first.
`ifndef HEC_CONSTS_SVH
`define HEC_CONSTS_SVH

`define HEC_CMD_EP_STATUS 8'h40
`define HEC_CMD_CLR_FEAT  8'hE0
`define HEC_CMD_SET_FEAT  8'hE8
`define HEC_CMD_ACK_SETUP 8'hF1
`define HEC_CMD_CLEAR_BUF 8'hF2
`define HEC_CMD_FRAME     8'hF5
`define HEC_CMD_RESUME    8'hF6
`define HEC_CMD_CHG_BITS  8'hF7
`define HEC_CMD_VALIDATE  8'hFA
`define HEC_CMD_SELECT    8'h00

`define HEC_F_ENABLE  8'h00
`define HEC_F_SUSPEND 8'h01
`define HEC_F_RESET   8'h02
`define HEC_F_POWER   8'h03
`define HEC_C_CONNECT 8'h04
`define HEC_C_ENABLE  8'h05
`define HEC_C_SUSPEND 8'h06
`define HEC_C_OVERCUR 8'h07

`define HEC_ST_CONNECT 0
`define HEC_ST_ENABLE  1
`define HEC_ST_SUSPEND 2
`define HEC_ST_OVERCUR 3
`define HEC_ST_RESET   4
`define HEC_ST_POWER   5
`define HEC_ST_LOWSPD  6

`define HEC_EP_STALL_BIT 0
`define HEC_EP_CTRL_OUT  0
`define HEC_EP_CTRL_IN   1
`define HEC_CHG_LOCAL    0
`define HEC_CHG_EMBED    1

`define HEC_CLK_KHZ       250000
`define HEC_PORT_RESET_MS 10
`define HEC_RESUME_MS     10

`endif

// ===== shared/hec_pkg.sv
// Types shared by the hub command interpreter
package hec_pkg;
	typedef logic [7:0] hec_byte_t;
	typedef enum logic [1:0] {ph_idle, ph_first, ph_second, ph_done} hec_phase_e;
endpackage

// ===== shared/hec_link_if.sv
// Toggle handshake between link clock domain and core clock domain
interface hec_link_if import hec_pkg::*; ();
	logic      cmd_tgl;
	logic      wr_tgl;
	logic      rd_tgl;
	hec_byte_t wr_byte;
	logic      rd_ack_tgl;
	hec_byte_t rd_byte;
	modport link (output cmd_tgl, wr_tgl, rd_tgl, wr_byte, input rd_ack_tgl, rd_byte);
	modport core (input cmd_tgl, wr_tgl, rd_tgl, wr_byte, output rd_ack_tgl, rd_byte);
endinterface

// ===== core/hec_link.sv
// Link clock front end: turns link strobes into toggles, returns read bytes
module hec_link
	import hec_pkg::*;
(
	input  wire logic      link_clk,       // Link clock
	input  wire logic      reset,          // Async reset, active high
	input  wire logic      link_cmd_valid, // Command byte strobe
	input  wire logic      link_wr_valid,  // Data write strobe
	input  wire logic      link_rd_req,    // Data read request
	input  wire hec_byte_t link_wdata,     // Command or write byte
	output logic           link_rd_valid,  // Read byte ready
	output hec_byte_t      link_rdata,     // Read byte
	hec_link_if.link       lk              // Toward core domain
);
	// ==========================================
	// Reset release on link clock
	logic [1:0] lrst;
	always_ff @(posedge link_clk or posedge reset) begin
		if (reset)
			lrst <= 2'b11;
		else
			lrst <= {lrst[0], 1'b0};
	end

	// ==========================================
	// Request capture
	always_ff @(posedge link_clk or posedge lrst[1]) begin
		if (lrst[1]) begin
			lk.cmd_tgl <= 1'b0;
			lk.wr_tgl  <= 1'b0;
			lk.rd_tgl  <= 1'b0;
			lk.wr_byte <= '0;
		end else begin
			if (link_cmd_valid) begin
				lk.cmd_tgl <= ~lk.cmd_tgl;
				lk.wr_byte <= link_wdata;
			end else if (link_wr_valid) begin
				lk.wr_tgl  <= ~lk.wr_tgl;
				lk.wr_byte <= link_wdata;
			end
			if (link_rd_req)
				lk.rd_tgl <= ~lk.rd_tgl;
		end
	end

	// ==========================================
	// Read answer return
	logic [2:0] ack_s;
	always_ff @(posedge link_clk or posedge lrst[1]) begin
		if (lrst[1]) begin
			ack_s         <= '0;
			link_rd_valid <= 1'b0;
			link_rdata    <= '0;
		end else begin
			ack_s         <= {ack_s[1:0], lk.rd_ack_tgl};
			link_rd_valid <= ack_s[2] ^ ack_s[1];
			if (ack_s[2] ^ ack_s[1])
				link_rdata <= lk.rd_byte;
		end
	end
endmodule // hec_link

// ===== verif/hec_mcu_model.sv
// Microcontroller model on the far side of the command link
module hec_mcu_model
	import hec_pkg::*;
(
	input  wire logic link_clk,       // Link clock
	input  wire logic link_rd_valid,  // Read byte ready
	output logic      link_cmd_valid, // Command strobe
	output logic      link_wr_valid,  // Write strobe
	output logic      link_rd_req,    // Read request
	output hec_byte_t link_wdata      // Command or data byte
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{link_cmd_valid, link_wr_valid, link_rd_req} = 3'b000;
		link_wdata = 8'h00;
	end
	// Kind 0 command, 1 write, 2 read; one byte per transfer
	task automatic xfer(input int kind, input hec_byte_t b);
		@(posedge link_clk);
		link_cmd_valid <= (kind == 0);
		link_wr_valid  <= (kind == 1);
		link_rd_req    <= (kind == 2);
		link_wdata     <= b;
		@(posedge link_clk);
		{link_cmd_valid, link_wr_valid, link_rd_req} <= 3'b000;
		link_wdata <= ~b;
		// Answer lands within eight edges
		repeat ((kind == 2) ? 8 : 3) @(posedge link_clk);
	endtask
endmodule // hec_mcu_model

// ===== verif/hec_command_set_test.sv
// Self-checking bench for the hub command interpreter
module hec_command_set_test
	import hec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset = 1, link_clk = 0, usb_setup, usb_sof_valid, cfg_mode;
	logic link_cmd_valid, link_wr_valid, link_rd_req, link_rd_valid, port_power, upstream_resume;
	hec_byte_t link_wdata, link_rdata;
	logic [4:0] usb_out_done, usb_in_sent, ep_full, ep_stall, ep_data1;
	logic [3:0] port_connect, port_low_speed, port_overcurrent_n, port_resume;
	logic [3:0] port_enable, port_suspend, port_bus_reset;
	logic [5:0] hub_change;
	logic [10:0] usb_sof_frame, frame;
	int fails = 0, checks = 0;
	hec_byte_t exp_q[$];
	hec_command_set #(.PORT_RESET_CYCLES(200), .RESUME_CYCLES(100)) i_hec_command_set (
		.clk                (clk),
		.reset              (reset),
		.link_clk           (link_clk),
		.link_cmd_valid     (link_cmd_valid),
		.link_wr_valid      (link_wr_valid),
		.link_rd_req        (link_rd_req),
		.link_wdata         (link_wdata),
		.link_rd_valid      (link_rd_valid),
		.link_rdata         (link_rdata),
		.usb_out_done       (usb_out_done),
		.usb_in_sent        (usb_in_sent),
		.usb_setup          (usb_setup),
		.usb_sof_valid      (usb_sof_valid),
		.usb_sof_frame      (usb_sof_frame),
		.ep_full            (ep_full),
		.ep_stall           (ep_stall),
		.ep_data1           (ep_data1),
		.cfg_mode           (cfg_mode),
		.port_connect       (port_connect),
		.port_low_speed     (port_low_speed),
		.port_overcurrent_n (port_overcurrent_n),
		.port_resume        (port_resume),
		.port_power         (port_power),
		.port_enable        (port_enable),
		.port_suspend       (port_suspend),
		.port_bus_reset     (port_bus_reset),
		.upstream_resume    (upstream_resume),
		.hub_change         (hub_change)
	);
	hec_mcu_model i_hec_mcu_model (
		.link_clk       (link_clk),
		.link_rd_valid  (link_rd_valid),
		.link_cmd_valid (link_cmd_valid),
		.link_wr_valid  (link_wr_valid),
		.link_rd_req    (link_rd_req),
		.link_wdata     (link_wdata)
	);
	always #2 clk = ~clk;
	initial begin
		#1.3;
		forever #16 link_clk = ~link_clk;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
		checks++;
		if (seen !== want) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic lnk(input int k, input hec_byte_t b);
		i_hec_mcu_model.xfer(k, b);
	endtask
	task automatic rd(input hec_byte_t e);
		exp_q.push_back(e);
		lnk(2, 8'h00);
	endtask
	// ==========================================
	// Read monitor
	always @(negedge link_clk)
		if (link_rd_valid === 1'b1)
			check("link_rdata", 16'(link_rdata), 16'((exp_q.size() > 0) ? exp_q.pop_front() : 8'h00));
	initial begin
		#100000;
		fails++;
		print_verdict();
	end
	// ==========================================
	// Main sequence
	initial begin
		{usb_out_done, usb_in_sent, usb_setup, usb_sof_valid, usb_sof_frame, cfg_mode} = '0;
		{port_connect, port_low_speed, port_overcurrent_n, port_resume} = 16'h13F0;
		void'($urandom(32'h9462));
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge link_clk);
		frame = 11'($urandom);
		@(posedge clk) {usb_sof_valid, usb_sof_frame} <= {1'b1, frame};
		@(posedge clk) usb_sof_valid <= 1'b0;
		lnk(0, 8'hF5);
		rd(frame[7:0]);
		rd({5'h00, frame[10:8]});
		lnk(0, 8'hE8);
		lnk(1, 8'h03);
		check("port_power", 16'(port_power), 16'h0001);
		lnk(0, 8'hE0);
		rd(8'h61);
		lnk(0, 8'hE1);
		rd(8'h20);
		lnk(0, 8'hE8);
		lnk(1, 8'h02);
		check("port_bus_reset", 16'(port_bus_reset), 16'h0001);
		repeat (250) @(posedge clk);
		check("port_enable", 16'({port_bus_reset, port_enable}), 16'h0001);
		lnk(0, 8'hF6);
		check("resume_on", 16'(upstream_resume), 16'h0001);
		repeat (110) @(posedge clk);
		check("resume_off", 16'(upstream_resume), 16'h0000);
		port_resume <= 4'h2;
		repeat (10) @(posedge clk);
		check("resume_auto", 16'(upstream_resume), 16'h0001);
		@(posedge clk) usb_out_done <= 5'h01;
		@(posedge clk) usb_out_done <= 5'h00;
		repeat (2) @(posedge clk);
		check("ep0_full", 16'(ep_full[0]), 16'h0001);
		lnk(0, 8'h00);
		lnk(0, 8'hF2);
		check("ep0_clear", 16'(ep_full[0]), 16'h0000);
		lnk(0, 8'h03);
		lnk(0, 8'hFA);
		check("ep3_valid", 16'(ep_full[3]), 16'h0001);
		@(posedge clk) usb_in_sent <= 5'h08;
		@(posedge clk) usb_in_sent <= 5'h00;
		repeat (2) @(posedge clk);
		check("ep3_sent", 16'({ep_full[3], ep_data1[3]}), 16'h0001);
		lnk(0, 8'h43);
		lnk(1, 8'h01);
		check("ep3_stall", 16'(ep_stall[3]), 16'h0001);
		lnk(0, 8'h43);
		lnk(1, 8'h00);
		check("ep3_reinit", 16'({ep_stall[3], ep_full[3], ep_data1[3]}), 16'h0000);
		@(posedge clk) usb_setup <= 1'b1;
		@(posedge clk) usb_setup <= 1'b0;
		repeat (2) @(posedge clk);
		check("setup_flush", 16'(ep_full[1:0]), 16'h0001);
		lnk(0, 8'h01);
		lnk(0, 8'hFA);
		check("setup_lock", 16'(ep_full[1]), 16'h0000);
		lnk(0, 8'hF1);
		lnk(0, 8'hFA);
		check("setup_ack", 16'(ep_full[1]), 16'h0001);
		lnk(0, 8'h00);
		lnk(0, 8'hF1);
		lnk(0, 8'hF7);
		lnk(1, 8'h02);
		check("hub_change", 16'(hub_change[1]), 16'h0001);
		lnk(0, 8'hE8);
		lnk(1, 8'h01);
		check("port_suspend", 16'(port_suspend), 16'h0001);
		lnk(0, 8'hE8);
		lnk(1, 8'h03);
		@(posedge clk) {cfg_mode, port_overcurrent_n} <= 5'h1D;
		lnk(0, 8'hE1);
		rd(8'h28);
		rd(8'h08);
		lnk(0, 8'hE1);
		lnk(1, 8'h07);
		check("oc_change_clear", 16'(hub_change[3]), 16'h0000);
		lnk(0, 8'hE0);
		lnk(1, 8'h03);
		check("power_off", 16'({port_power, port_enable}), 16'h0000);
		check("reads_left", 16'(exp_q.size()), 16'h0000);
		print_verdict();
	end
endmodule // hec_command_set_test
